// [dv/tmrc_timer_test.sv]
module tmrc_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Bus and pin stimulus
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic ext_clk_in = 1'b0;
  logic sleep_in = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic period_match_output;
  logic rd_pend = 1'b0;
  logic [31:0] q_exp[$];
  logic [31:0] q_msk[$];
  int fail_count = 0;
  int tests_run = 0;
  logic [7:0] v_hi;
  logic [7:0] v_lo;
  int gap;
  // Mode table: second control value, sleep level, rising-edge spacing of the output
  logic [7:0] mode_c2[10] = '{8'h50, 8'h52, 8'h40, 8'h20, 8'h31, 8'h10, 8'h11, 8'h00, 8'h50, 8'h40};
  logic mode_sl[10] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  int mode_gap[10] = '{4, 16, 16, 16, 32, 40, 80, 40, 4, 0};

  always #20 hclk = ~hclk;

  // External source toggles every five cycles, so spacing is exact even after the syncer
  always
  begin
    repeat (5) @(posedge hclk);
    ext_clk_in <= ~ext_clk_in;
  end

  tmrc_timer DUT (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .ext_clk_in(ext_clk_in),
    .sleep_in(sleep_in),
    .period_match_output(period_match_output)
  );

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Read data is compared at the data-phase edge against the oldest note
  always @(posedge hclk)
  begin
    if (rd_pend && hreadyout === 1'b1)
    begin
      if (q_exp.size() == 0)
        check("read note", 32'h1, 32'h0);
      else
      begin
        check("hrdata", q_exp[0] & q_msk[0], hrdata & q_msk[0]);
        check("hresp", 32'h0, {31'h0, hresp});
        void'(q_exp.pop_front());
        void'(q_msk.pop_front());
      end
    end
    if (hreadyout === 1'b1)
      rd_pend <= hsel && htrans == tmrc_pkg::HTRANS_NONSEQ && !hwrite;
  end

  // ----------------------------------------
  // Bus master
  // ----------------------------------------
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      @(posedge hclk);
      n++;
    end
    if (n >= 50)
    begin
      fail_count++;
      $display("CHECK FAILED hready expected 1 seen %b", hreadyout);
      conclude();
    end
  endtask : wait_ready

  // Mask m selects the bits whose value is known in advance
  task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d, input logic [7:0] e,
                     input logic [7:0] m);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= tmrc_pkg::HTRANS_NONSEQ;
    wait_ready();
    if (!wr)
    begin
      q_exp.push_back({24'h0, e});
      q_msk.push_back({24'hffffff, m});
    end
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    wait_ready();
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 8'h0, 8'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    bus(a, 1'b0, 8'h0, e, m);
  endtask : rd

  // Cycles between the first two rising edges of the output; zero if fewer than two come within 4000 cycles
  task automatic measure(output int g);
    int n;
    int t1;
    logic p;
    g = 0;
    n = 0;
    t1 = -1;
    p = period_match_output;
    while (n < 4000 && g == 0)
    begin
      @(posedge hclk);
      n++;
      if (period_match_output === 1'b1 && p !== 1'b1)
      begin
        if (t1 < 0)
          t1 = n;
        else
          g = n - t1;
      end
      p = period_match_output;
    end
  endtask : measure

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    v_hi = 8'($urandom(78));
    v_lo = 8'($urandom);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(tmrc_pkg::OFF_CTRL1, tmrc_pkg::RST_CTRL1, 8'hff);
    rd(tmrc_pkg::OFF_CTRL2, tmrc_pkg::RST_CTRL2, 8'hff);
    rd(tmrc_pkg::OFF_LOW, 8'h00, 8'hff);
    rd(tmrc_pkg::OFF_HIGH, 8'hff, 8'hff);
    rd(8'h10, 8'h00, 8'hff);
    $display("reset values done");
    // Stopped 16-bit pair: the buffer is polluted, then a low read must restore the real high byte
    wr(tmrc_pkg::OFF_CTRL1, 8'h10);
    wr(tmrc_pkg::OFF_HIGH, v_hi);
    wr(tmrc_pkg::OFF_LOW, v_lo);
    wr(tmrc_pkg::OFF_HIGH, ~v_hi);
    rd(tmrc_pkg::OFF_LOW, v_lo, 8'hff);
    rd(tmrc_pkg::OFF_HIGH, v_hi, 8'hff);
    // Sixty-two counts from 0x00f0 (60 idle cycles plus the stopping write) carry into the high byte
    wr(tmrc_pkg::OFF_HIGH, 8'h00);
    wr(tmrc_pkg::OFF_LOW, 8'hf0);
    wr(tmrc_pkg::OFF_CTRL2, 8'h50);
    wr(tmrc_pkg::OFF_CTRL1, 8'h90);
    repeat (60) @(posedge hclk);
    wr(tmrc_pkg::OFF_CTRL1, 8'h10);
    rd(tmrc_pkg::OFF_LOW, 8'h2e, 8'hff);
    rd(tmrc_pkg::OFF_HIGH, 8'h01, 8'hff);
    $display("16-bit tests done");
    // 8-bit period 3: the output rises every four count steps, except in sync mode under sleep, where it never rises
    wr(tmrc_pkg::OFF_CTRL1, 8'h80);
    for (int i = 0; i < 10; i++)
    begin
      sleep_in <= mode_sl[i];
      wr(tmrc_pkg::OFF_HIGH, 8'h03);
      wr(tmrc_pkg::OFF_LOW, 8'h00);
      wr(tmrc_pkg::OFF_CTRL2, mode_c2[i]);
      measure(gap);
      check("match spacing", 32'(mode_gap[i]), 32'(gap));
    end
    // Postscaler 1:2 passes every second match, so the output rises every eight counts
    sleep_in <= 1'b0;
    wr(tmrc_pkg::OFF_CTRL1, 8'h81);
    wr(tmrc_pkg::OFF_HIGH, 8'h03);
    wr(tmrc_pkg::OFF_LOW, 8'h00);
    wr(tmrc_pkg::OFF_CTRL2, 8'h50);
    measure(gap);
    check("postscaled spacing", 32'h8, 32'(gap));
    $display("8-bit mode tests done");
    conclude();
  end
endmodule : tmrc_timer_test

// [src/tmrc_pkg.sv]
package tmrc_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_LOW = 8'h08;
  localparam logic [7:0] OFF_HIGH = 8'h0c;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL1_EN_BIT = 7;
  localparam int CTRL1_OUT_BIT = 5;
  localparam int CTRL1_WIDTH_BIT = 4;
  localparam int CTRL2_SRC_LSB = 5;
  localparam int CTRL2_COUNT_SELECT_A_BIT = 4;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h00;
  localparam logic [7:0] RST_LOW = 8'h00;
  localparam logic [7:0] RST_HIGH = 8'hff;
  // ----------------------------------------
  // Clock source codes and timing
  // ----------------------------------------
  localparam logic [2:0] CS_EXT = 3'h0;
  localparam logic [2:0] CS_INST = 3'h1;
  localparam logic [2:0] CS_SYS = 3'h2;
  localparam logic [1:0] INST_LAST_PHASE = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : tmrc_pkg

// [src/tmrc_timer.sv]
// Summary of operation
// RQ1: One width bit in the first control register picks 8-bit or 16-bit counting.
// RQ2: In 16-bit width the high:low pair advances on each prescaled rising edge of the source.
// RQ3: In 16-bit width a low-byte read latches the real high byte into the high buffer.
// RQ4: In 16-bit width a low-byte write copies the high buffer into the real high byte.
// RQ5: In 8-bit width a low-byte match with the period buffer pulses the output, clears low, reloads period.
// RQ6: In 8-bit width both bytes are read and written directly; reset gives low zero and high all ones.
// RQ7: Writes to the low byte or either control register and any reset clear prescaler and postscaler.
// RQ8: A prescale select of zero bypasses the prescaler so each source edge adds one.
// RQ9: In timer use with prescale zero the count steps once per instruction cycle, else divided.
// RQ10: With the count_select_a bit set the count follows source edges directly and runs through sleep.
// RQ11: With the count_select_a bit clear counts are aligned to the instruction clock and capped at its rate.
// RQ12: A three-bit source field selects the external input, the instruction clock or the system clock.
// RQ13: A prescale select of k divides the source by two to the power k.
module tmrc_timer (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Timer pins
  input wire logic ext_clk_in,
  input wire logic sleep_in,
  output logic period_match_output
);
  // ----------------------------------------
  // Registers and internal state
  // ----------------------------------------
  logic [7:0] control_reg_first;
  logic [7:0] control_reg_second;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] real_high;
  logic [7:0] period_buf;
  logic [14:0] pre_cnt;
  logic [3:0] post_cnt;
  logic [1:0] phase;
  logic pend;
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  logic wr_en;
  logic [7:0] wr_addr;
  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  logic width_select;
  logic count_select_a;
  logic enable;
  logic [3:0] prescale_select;
  logic [3:0] post_sel;
  logic [2:0] src_sel;
  logic [14:0] pre_mask;
  logic src_edge;
  logic run;
  logic tick;
  logic inc;
  logic match;
  logic roll;
  logic post_hit;
  logic rd_low;
  logic addr_ok;
  logic wr_low;
  logic wr_high;
  logic wr_c1;
  logic wr_c2;
  logic clr_pre;

  // Field extraction
  assign width_select = control_reg_first[tmrc_pkg::CTRL1_WIDTH_BIT]; // see RQ1
  assign enable = control_reg_first[tmrc_pkg::CTRL1_EN_BIT];
  assign post_sel = control_reg_first[3:0];
  assign count_select_a = control_reg_second[tmrc_pkg::CTRL2_COUNT_SELECT_A_BIT];
  assign prescale_select = control_reg_second[3:0];
  assign src_sel = control_reg_second[tmrc_pkg::CTRL2_SRC_LSB +: 3];

  // Bus strobes; writes act in the data phase when hwdata is valid
  assign addr_ok = hsel && hready && (htrans == tmrc_pkg::HTRANS_NONSEQ);
  assign rd_low = addr_ok && !hwrite && (haddr[7:0] == tmrc_pkg::OFF_LOW);
  assign wr_low = wr_en && (wr_addr == tmrc_pkg::OFF_LOW);
  assign wr_high = wr_en && (wr_addr == tmrc_pkg::OFF_HIGH);
  assign wr_c1 = wr_en && (wr_addr == tmrc_pkg::OFF_CTRL1);
  assign wr_c2 = wr_en && (wr_addr == tmrc_pkg::OFF_CTRL2);
  assign clr_pre = wr_low || wr_c1 || wr_c2; // see RQ7

  // Source edge select; system clock gives an edge every cycle
  always_comb
  begin
    case (src_sel) // see RQ12
      tmrc_pkg::CS_EXT: src_edge = ext_s2 && !ext_s3;
      tmrc_pkg::CS_INST: src_edge = (phase == tmrc_pkg::INST_LAST_PHASE); // see RQ9
      tmrc_pkg::CS_SYS: src_edge = 1'b1;
      default: src_edge = 1'b0;
    endcase
  end

  // Divide by 2^k: tick when the low k prescaler bits are all ones
  assign pre_mask = 15'((16'h0001 << prescale_select) - 16'h0001); // see RQ13
  assign run = enable && (count_select_a || !sleep_in); // see RQ10
  assign tick = src_edge && run && ((pre_cnt & pre_mask) == pre_mask); // see RQ8
  // Sync mode only releases a count on the last instruction phase
  assign inc = count_select_a ? tick : (pend && (phase == tmrc_pkg::INST_LAST_PHASE)); // see RQ11
  assign match = !width_select && (count_low_byte == period_buf); // see RQ5
  assign roll = width_select && (count_low_byte == 8'hff) && (real_high == 8'hff);
  assign post_hit = (post_cnt == post_sel);

  // ----------------------------------------
  // Input synchroniser and instruction phase
  // ----------------------------------------
  // Two flops before use; the third only feeds the edge detector
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end
    else
    begin
      ext_s1 <= ext_clk_in;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // Instruction clock is system clock divided by four
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
  end

  // ----------------------------------------
  // Prescaler and sync holding flag
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pre_cnt <= 15'h0000;
    else if (clr_pre)
      pre_cnt <= 15'h0000; // see RQ7
    else if (src_edge && run)
      pre_cnt <= pre_cnt + 15'h0001; // see RQ2
  end

  // A new tick wins over a release in the same cycle, so none is lost
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pend <= 1'b0;
    else if (clr_pre)
      pend <= 1'b0;
    else if (tick && !count_select_a)
      pend <= 1'b1;
    else if (inc && !count_select_a)
      pend <= 1'b0;
  end

  // ----------------------------------------
  // Counter bytes
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count_low_byte <= tmrc_pkg::RST_LOW; // see RQ6
    else if (wr_low)
      count_low_byte <= hwdata[7:0];
    else if (inc && match)
      count_low_byte <= 8'h00; // see RQ5
    else if (inc)
      count_low_byte <= count_low_byte + 8'h01; // see RQ2
  end

  // Hidden high byte, only reached through the buffer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      real_high <= 8'h00;
    else if (wr_low && width_select)
      real_high <= count_high_byte; // see RQ4
    else if (inc && width_select && count_low_byte == 8'hff)
      real_high <= real_high + 8'h01; // see RQ2
  end

  // Buffer in 16-bit width, period register in 8-bit width
  // A read latch wins over a write that finishes in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count_high_byte <= tmrc_pkg::RST_HIGH; // see RQ6
    else if (rd_low && width_select)
      count_high_byte <= real_high; // see RQ3
    else if (wr_high)
      count_high_byte <= hwdata[7:0]; // see RQ6
  end

  // Period buffer reloads only on a match, so a new period starts cleanly
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      period_buf <= tmrc_pkg::RST_HIGH;
    else if (inc && match)
      period_buf <= count_high_byte; // see RQ5
  end

  // ----------------------------------------
  // Postscaler and output pulse
  // ----------------------------------------
  // Output stays high until the next count step, one prescaled period
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      post_cnt <= 4'h0;
      period_match_output <= 1'b0;
    end
    else if (clr_pre)
    begin
      post_cnt <= 4'h0; // see RQ7
      period_match_output <= 1'b0;
    end
    else if (inc && (match || roll))
    begin
      post_cnt <= post_hit ? 4'h0 : post_cnt + 4'h1;
      period_match_output <= post_hit; // see RQ5
    end
    else if (inc)
      period_match_output <= 1'b0;
  end

  // ----------------------------------------
  // Control registers and bus slave
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      control_reg_first <= tmrc_pkg::RST_CTRL1;
      control_reg_second <= tmrc_pkg::RST_CTRL2;
    end
    else
    begin
      if (wr_c1)
        control_reg_first <= hwdata[7:0] & ~(8'h01 << tmrc_pkg::CTRL1_OUT_BIT); // Output bit is read-only
      if (wr_c2)
        control_reg_second <= hwdata[7:0];
    end
  end

  // Address phase capture; the slave never stalls
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      wr_en <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data registered at the address phase; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_ok && !hwrite)
    begin
      case (haddr[7:0])
        tmrc_pkg::OFF_CTRL1: hrdata <= {24'h000000, control_reg_first | (8'(period_match_output) << tmrc_pkg::CTRL1_OUT_BIT)};
        tmrc_pkg::OFF_CTRL2: hrdata <= {24'h000000, control_reg_second};
        tmrc_pkg::OFF_LOW: hrdata <= {24'h000000, count_low_byte};
        tmrc_pkg::OFF_HIGH: hrdata <= {24'h000000, count_high_byte};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  match_clears_low_a: assert property (inc && match && !wr_low |=> count_low_byte == 8'h00) // see RQ5
    else $error("low byte not cleared on match");
  period_reload_a: assert property (inc && match |=> period_buf == $past(count_high_byte)) // see RQ5
    else $error("period buffer not reloaded");
  match_pulse_a: assert property (inc && match && post_hit && !clr_pre |=> period_match_output) // see RQ5
    else $error("match output missing");
  read_latch_a: assert property (rd_low && width_select |=> count_high_byte == $past(real_high)) // see RQ3
    else $error("high buffer not latched on low read");
  write_copy_a: assert property (wr_low && width_select |=> real_high == $past(count_high_byte)) // see RQ4
    else $error("high byte not loaded from buffer");
  scaler_clear_a: assert property (clr_pre |=> pre_cnt == 15'h0000 && post_cnt == 4'h0) // see RQ7
    else $error("prescaler or postscaler not cleared");
  bypass_tick_a: assert property (prescale_select == 4'h0 && src_edge && run |-> tick) // see RQ8
    else $error("bypassed prescaler lost an edge");
  sync_phase_a: assert property (inc && !count_select_a |-> phase == tmrc_pkg::INST_LAST_PHASE) // see RQ11
    else $error("sync count off instruction phase");
  divide_a: assert property (tick && prescale_select != 4'h0 |-> pre_cnt[0]) // see RQ13
    else $error("prescaler divide wrong");
  wide_wrap_a: assert property (roll && inc && !wr_low |=> count_low_byte == 8'h00 && real_high == 8'h00) // see RQ2
    else $error("16-bit wrap wrong");
  count_select_a_sleep_a: assert property (count_select_a && sleep_in && tick |-> inc) // see RQ10
    else $error("count_select_a count stalled in sleep");

  match_c: cover property (inc && match);
  wrap_c: cover property (inc && roll);
  sleep_c: cover property (count_select_a && sleep_in && inc);
  latch_c: cover property (rd_low && width_select);
endmodule : tmrc_timer
